// >>> design/mwcp_pkg.sv
package mwcp_pkg;
  // Link widths
  localparam int CA_W       = 10;
  localparam int DQ_W       = 16;
  localparam int BANK_W     = 4;
  localparam int COL_W      = 6;
  localparam int BURST_LEN  = 16;
  localparam int MASK_W     = 16;
  localparam int NUM_BANKS  = 16;
  localparam int GROUP_W    = 2;
  // Command codes on ca[9:7] of the first cycle
  localparam logic [2:0] CMD_NOP   = 3'h0;
  localparam logic [2:0] CMD_ACT   = 3'h1;
  localparam logic [2:0] CMD_WOM   = 3'h2;
  localparam logic [2:0] CMD_WDM   = 3'h3;
  localparam logic [2:0] CMD_READ  = 3'h4;
  localparam int CMD_LSB    = 7;
  localparam int BANK_LSB   = 0;
  localparam int AP_BIT     = 4;
  // Timing counts in link clock cycles (plain defaults)
  localparam int T_CCD_S    = 2;
  localparam int T_CCD_L    = 4;
  localparam int T_WTR_S    = 5;
  localparam int T_WTR_L    = 8;
  localparam int T_RCD_WR   = 3;
  localparam int T_RCD_RD   = 4;
  localparam int T_WR       = 6;
  localparam int WRITE_LAT  = 2;
  // Link clock divider: half period in system cycles
  localparam int LCK_HALF   = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW    = 3;
endpackage

// >>> design/mwcp_link_if.sv
`timescale 1ns/1ps
interface mwcp_link_if;
  import mwcp_pkg::*;
  logic              lck;
  logic [CA_W-1:0]   ca_rise;
  logic [CA_W-1:0]   ca_fall;
  logic [DQ_W-1:0]   dq;
  logic              dq_valid;
  logic              write_done;
  modport host (output lck, ca_rise, ca_fall, dq, dq_valid,
                input write_done);
  modport device (input lck, ca_rise, ca_fall, dq, dq_valid,
                  output write_done);
endinterface

// >>> design/mwcp_fifo.sv
`timescale 1ns/1ps
module mwcp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // Full when pointers differ only in wrap bit
  assign o_in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) ||
                       (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
  assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
  assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// >>> design/mwcp_host.sv
`timescale 1ns/1ps
module mwcp_host
  import mwcp_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_req_valid,
  input  wire logic [2:0]       i_req_cmd,
  input  wire logic [BANK_W-1:0] i_req_bank,
  input  wire logic [COL_W-1:0] i_req_col,
  input  wire logic             i_req_ap,
  input  wire logic [MASK_W-1:0] i_req_mask,
  input  wire logic             i_bank_groups_on,
  output logic                  o_req_ready,
  input  wire logic             i_data_valid,
  input  wire logic [DQ_W-1:0]  i_data,
  output logic                  o_data_ready,
  mwcp_link_if.host             link
);
  typedef enum logic [3:0] {
    MWCP_H_CMD  = 4'b0001,
    MWCP_H_MASK = 4'b0010,
    MWCP_H_DATA = 4'b0100,
    MWCP_H_IDLE = 4'b1000
  } mwcp_hstate_t;

  mwcp_hstate_t     state_reg;
  logic             lck_reg;
  logic [2:0]       div_reg;
  logic             lck_fall;
  logic [7:0]       gap_reg;
  logic [NUM_BANKS-1:0] open_reg;
  logic [7:0]       rcd_reg [NUM_BANKS];
  logic             last_wr_reg;
  logic [GROUP_W-1:0] last_grp_reg;
  logic [MASK_W-1:0] mask_reg;
  logic [4:0]       beat_reg;
  logic [4:0]       wl_reg;
  logic [CA_W-1:0]  ca_rise_reg;
  logic [CA_W-1:0]  ca_fall_reg;
  logic [DQ_W-1:0]  dq_reg;
  logic             dq_valid_reg;
  logic             legal;
  logic             same_grp;
  logic             is_wr;
  logic [7:0]       need;

  // Host makes the link clock by dividing its own clock
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= '0;
      lck_reg <= 1'b0;
    end else if (div_reg == 3'(LCK_HALF - 1)) begin
      div_reg <= '0;
      lck_reg <= ~lck_reg;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end
  // Launch on the falling link edge, half a period before the sampling rise
  assign lck_fall = lck_reg && (div_reg == 3'(LCK_HALF - 1));

  assign is_wr    = (i_req_cmd == CMD_WOM) || (i_req_cmd == CMD_WDM);
  assign same_grp = i_bank_groups_on &&
                    (i_req_bank[BANK_W-1 -: GROUP_W] == last_grp_reg);

  // Spacing required since the last column command
  always_comb begin
    need = 8'h0;
    if (is_wr && last_wr_reg) begin
      need = same_grp ? 8'(T_CCD_L) : 8'(T_CCD_S); // R1
    end else if (i_req_cmd == CMD_READ && last_wr_reg) begin
      need = same_grp ? 8'(T_WTR_L) : 8'(T_WTR_S); // R2
    end
  end

  // Column commands need an open row and its activate delay
  always_comb begin
    legal = gap_reg >= need;
    if (is_wr || i_req_cmd == CMD_READ) begin
      legal = legal && open_reg[i_req_bank] &&
              (rcd_reg[i_req_bank] == 8'h0); // R3
    end
  end

  assign o_req_ready  = (state_reg == MWCP_H_CMD) && lck_fall && legal;
  assign o_data_ready = (state_reg == MWCP_H_DATA) && lck_fall &&
                        (wl_reg == 5'h0);

  // Command, mask and data sequencer
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg    <= MWCP_H_CMD;
      ca_rise_reg  <= '0;
      ca_fall_reg  <= '0;
      mask_reg     <= '0;
      beat_reg     <= '0;
      wl_reg       <= '0;
      dq_reg       <= '0;
      dq_valid_reg <= 1'b0;
    end else if (lck_fall) begin
      ca_rise_reg  <= '0;
      ca_fall_reg  <= '0;
      dq_valid_reg <= 1'b0;
      case (state_reg)
        MWCP_H_CMD: begin
          if (i_req_valid && legal) begin
            ca_rise_reg <= {i_req_cmd, 3'h0, i_req_bank};
            // Auto precharge owns its bit; column bits sit around it
            ca_fall_reg <= {3'h0, i_req_col[5:4], i_req_ap,
                            i_req_col[3:0]}; // R4
            mask_reg    <= i_req_mask;
            beat_reg    <= '0;
            wl_reg      <= 5'(WRITE_LAT);
            if (i_req_cmd == CMD_WDM) begin
              state_reg <= MWCP_H_MASK; // R8
            end else if (i_req_cmd == CMD_WOM) begin
              state_reg <= MWCP_H_DATA;
            end
          end
        end
        MWCP_H_MASK: begin
          // Mask rides in the NOP slot after the command cycle
          ca_rise_reg <= {2'h0, mask_reg[7:0]}; // R5 R6 R9 R10
          ca_fall_reg <= {2'h0, mask_reg[15:8]}; // R10
          state_reg   <= MWCP_H_DATA;
        end
        MWCP_H_DATA: begin
          if (wl_reg != 5'h0) begin
            wl_reg <= wl_reg - 5'h1;
          end else begin
            dq_valid_reg <= 1'b1;
            dq_reg       <= i_data_valid ? i_data : '0;
            beat_reg     <= beat_reg + 5'h1;
            if (beat_reg == 5'(BURST_LEN - 1)) begin
              state_reg <= MWCP_H_CMD;
            end
          end
        end
        default: state_reg <= MWCP_H_CMD;
      endcase
    end
  end

  // Bookkeeping of open rows and column spacing
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_reg      <= 8'hff;
      open_reg     <= '0;
      last_wr_reg  <= 1'b0;
      last_grp_reg <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        rcd_reg[b] <= '0;
      end
    end else if (lck_fall) begin
      if (gap_reg != 8'hff) begin
        gap_reg <= gap_reg + 8'h1;
      end
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (rcd_reg[b] != 8'h0) begin
          rcd_reg[b] <= rcd_reg[b] - 8'h1;
        end
      end
      if (state_reg == MWCP_H_CMD && i_req_valid && legal) begin
        if (i_req_cmd == CMD_ACT) begin
          open_reg[i_req_bank] <= 1'b1; // R3
          rcd_reg[i_req_bank]  <= 8'(T_RCD_WR > T_RCD_RD ?
                                     T_RCD_WR : T_RCD_RD);
        end else if (is_wr || i_req_cmd == CMD_READ) begin
          gap_reg      <= 8'h1;
          last_wr_reg  <= is_wr;
          last_grp_reg <= i_req_bank[BANK_W-1 -: GROUP_W];
          if (i_req_ap) begin
            open_reg[i_req_bank] <= 1'b0;
          end
        end
      end
    end
  end

  assign link.lck      = lck_reg;
  assign link.ca_rise  = ca_rise_reg;
  assign link.ca_fall  = ca_fall_reg;
  assign link.dq       = dq_reg;
  assign link.dq_valid = dq_valid_reg;
endmodule

// >>> design/mwcp_device.sv
`timescale 1ns/1ps
// Behaviour
// R1: Host spaces writes by group delay
// R2: Host waits write-to-read delay by group
// R3: Host activates row, waits activate delay
// R4: Auto precharge at earliest legal time
// R5: Mask travels on command bus after address
// R6: Host puts mask in following NOP slot
// R7: Mask zero stores, one inhibits
// R8: Masked write has two cycles
// R9: Second cycle holds only mask bits
// R10: Rise bits mask 0-7, fall 8-15
// R11: Masked write after write may modify
// R12: Masked write otherwise like plain write
// R13: Bursts of sixteen, never truncated
// R14: Set bit blocks all sixteen lines
module mwcp_device
  import mwcp_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  mwcp_link_if.device            link,
  output logic                   o_wr_valid,
  output logic [BANK_W-1:0]      o_wr_bank,
  output logic [COL_W+3:0]       o_wr_addr,
  output logic [DQ_W-1:0]        o_wr_data,
  output logic                   o_wr_rmw,
  input  wire logic              i_wr_ready,
  output logic                   o_pre_valid,
  output logic [BANK_W-1:0]      o_pre_bank
);
  typedef enum logic [3:0] {
    MWCP_D_CMD  = 4'b0001,
    MWCP_D_MASK = 4'b0010,
    MWCP_D_DATA = 4'b0100,
    MWCP_D_IDLE = 4'b1000
  } mwcp_dstate_t;

  localparam int FW = 1 + BANK_W + COL_W + 4 + DQ_W + 1;

  mwcp_dstate_t      state_reg;
  logic [2:0]        lck_sync_reg;
  logic [CA_W-1:0]   rise_s1_reg, rise_s2_reg;
  logic [CA_W-1:0]   fall_s1_reg, fall_s2_reg;
  logic [DQ_W-1:0]   dq_s1_reg, dq_s2_reg;
  logic              dv_s1_reg, dv_s2_reg;
  logic              lck_rise;
  logic [2:0]        cmd;
  logic [BANK_W-1:0] bank_reg;
  logic [COL_W-1:0]  col_reg;
  logic              ap_reg;
  logic              masked_reg;
  logic              rmw_reg;
  logic [MASK_W-1:0] mask_reg;
  logic [4:0]        beat_reg;
  logic [BANK_W-1:0] last_bank_reg;
  logic              last_wr_reg;
  logic [7:0]        pre_cnt_reg;
  logic [BANK_W-1:0] pre_bank_reg;
  logic              push;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [FW-1:0]     fifo_in;
  logic [FW-1:0]     fifo_out;
  logic              out_valid_reg;
  logic [FW-1:0]     out_reg;
  logic              pre_valid_reg;

  // Two-flop synchronisers for the link pins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lck_sync_reg <= '0;
      rise_s1_reg  <= '0;
      rise_s2_reg  <= '0;
      fall_s1_reg  <= '0;
      fall_s2_reg  <= '0;
      dq_s1_reg    <= '0;
      dq_s2_reg    <= '0;
      dv_s1_reg    <= 1'b0;
      dv_s2_reg    <= 1'b0;
    end else begin
      lck_sync_reg <= {lck_sync_reg[1:0], link.lck};
      rise_s1_reg  <= link.ca_rise;
      rise_s2_reg  <= rise_s1_reg;
      fall_s1_reg  <= link.ca_fall;
      fall_s2_reg  <= fall_s1_reg;
      dq_s1_reg    <= link.dq;
      dq_s2_reg    <= dq_s1_reg;
      dv_s1_reg    <= link.dq_valid;
      dv_s2_reg    <= dv_s1_reg;
    end
  end
  // Edge found on synchronised stages only
  assign lck_rise = lck_sync_reg[1] && !lck_sync_reg[2];
  assign cmd      = rise_s2_reg[CA_W-1 -: 3];

  // Command decode, mask capture and burst count
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg     <= MWCP_D_CMD;
      bank_reg      <= '0;
      col_reg       <= '0;
      ap_reg        <= 1'b0;
      masked_reg    <= 1'b0;
      rmw_reg       <= 1'b0;
      mask_reg      <= '0;
      beat_reg      <= '0;
      last_bank_reg <= '0;
      last_wr_reg   <= 1'b0;
    end else if (lck_rise) begin
      case (state_reg)
        MWCP_D_CMD: begin
          // Both write kinds capture address alike
          if (cmd == CMD_WOM || cmd == CMD_WDM) begin // R12
            bank_reg   <= rise_s2_reg[BANK_W-1:0];
            col_reg    <= {fall_s2_reg[6:5], fall_s2_reg[3:0]};
            ap_reg     <= fall_s2_reg[AP_BIT];
            masked_reg <= cmd == CMD_WDM;
            mask_reg   <= '0;
            beat_reg   <= '0;
            // Merge needed for a masked write when the last column command was a write to this bank
            rmw_reg    <= (cmd == CMD_WDM) && last_wr_reg &&
                          (last_bank_reg == rise_s2_reg[BANK_W-1:0]); // R11
            last_bank_reg <= rise_s2_reg[BANK_W-1:0];
            last_wr_reg   <= 1'b1;
            state_reg  <= (cmd == CMD_WDM) ? MWCP_D_MASK
                                           : MWCP_D_DATA; // R8
          end else if (cmd == CMD_READ) begin
            last_wr_reg <= 1'b0;
          end
        end
        MWCP_D_MASK: begin
          // Second cycle is only mask bits
          mask_reg  <= {fall_s2_reg[7:0], rise_s2_reg[7:0]}; // R5 R9 R10
          state_reg <= MWCP_D_DATA;
        end
        MWCP_D_DATA: begin
          // Burst runs to sixteen; commands wait meanwhile
          if (dv_s2_reg) begin
            beat_reg <= beat_reg + 5'h1;
            if (beat_reg == 5'(BURST_LEN - 1)) begin // R13
              state_reg <= MWCP_D_CMD;
            end
          end
        end
        default: state_reg <= MWCP_D_CMD;
      endcase
    end
  end

  // Masked beats never enter the store path
  assign push = lck_rise && state_reg == MWCP_D_DATA && dv_s2_reg &&
                !(masked_reg && mask_reg[beat_reg[3:0]]); // R7 R14
  assign fifo_in = {rmw_reg, bank_reg, col_reg, beat_reg[3:0],
                    dq_s2_reg, masked_reg};

  mwcp_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (!out_valid_reg || i_wr_ready),
    .o_out_data  (fifo_out)
  );

  // Registered array write port
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_valid_reg <= 1'b0;
      out_reg       <= '0;
    end else if (!out_valid_reg || i_wr_ready) begin
      out_valid_reg <= fifo_out_valid;
      out_reg       <= fifo_out;
    end
  end

  // Auto precharge once write recovery has elapsed
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_cnt_reg   <= '0;
      pre_bank_reg  <= '0;
      pre_valid_reg <= 1'b0;
    end else begin
      pre_valid_reg <= 1'b0;
      if (lck_rise && state_reg == MWCP_D_DATA && dv_s2_reg &&
          beat_reg == 5'(BURST_LEN - 1) && ap_reg) begin
        pre_cnt_reg  <= 8'(T_WR);
        pre_bank_reg <= bank_reg;
      end else if (lck_rise && pre_cnt_reg != 8'h0) begin
        pre_cnt_reg <= pre_cnt_reg - 8'h1;
        if (pre_cnt_reg == 8'h1) begin
          pre_valid_reg <= 1'b1; // R4
        end
      end
    end
  end

  assign o_wr_valid      = out_valid_reg;
  assign o_wr_rmw        = out_reg[FW-1];
  assign o_wr_bank       = out_reg[FW-2 -: BANK_W];
  assign o_wr_addr       = out_reg[FW-2-BANK_W -: COL_W+4];
  assign o_wr_data       = out_reg[DQ_W:1];
  assign o_pre_valid     = pre_valid_reg;
  assign o_pre_bank      = pre_bank_reg;
  assign link.write_done = !fifo_in_ready;
endmodule

// >>> verification/mwcp_sva.sv
`timescale 1ns/1ps
module mwcp_sva
  import mwcp_pkg::*;
(
  input wire logic            i_clk,
  input wire logic            i_rstn,
  input wire logic            lck,
  input wire logic [CA_W-1:0] ca_rise,
  input wire logic [CA_W-1:0] ca_fall,
  input wire logic [DQ_W-1:0] dq,
  input wire logic            dq_valid,
  input wire logic            write_done
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  logic                 lck_q_reg;
  logic                 mslot_reg;
  logic [7:0]           vcnt_reg;
  logic [3:0]           wgap_reg;
  logic [NUM_BANKS-1:0] open_reg;
  // Decode of the command slot seen at a link clock rise
  wire [2:0]        cmd    = ca_rise[CMD_LSB+:3];
  wire [BANK_W-1:0] bank   = ca_rise[BANK_LSB+:BANK_W];
  wire              rise   = lck & ~lck_q_reg;
  // Host launches command and data on the falling link edge
  wire              fall   = ~lck & lck_q_reg;
  wire              is_cmd = rise & ~mslot_reg;
  wire              is_wr  = is_cmd & (cmd == CMD_WOM | cmd == CMD_WDM);
  wire              is_rd  = is_cmd & (cmd == CMD_READ);
  // Mask slot holds no command, else its bits would decode as one
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lck_q_reg <= 1'b0;
      mslot_reg <= 1'b0;
    end else begin
      lck_q_reg <= lck;
      if (rise) mslot_reg <= is_cmd & (cmd == CMD_WDM);
    end
  end
  // Count of system cycles with data valid; wraps at 256, only the low seven bits matter
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) vcnt_reg <= 8'h00;
    else vcnt_reg <= dq_valid ? vcnt_reg + 8'h01 : 8'h00;
  end
  // Link clock rises since the last write, saturating
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) wgap_reg <= 4'hf;
    else if (is_wr) wgap_reg <= 4'h0;
    else if (rise && wgap_reg != 4'hf) wgap_reg <= wgap_reg + 4'h1;
  end
  // Opened banks; never closed, so the check is lenient
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) open_reg <= '0;
    else if (is_cmd && cmd == CMD_ACT) open_reg[bank] <= 1'b1;
  end
  lck_period_a: assert property ($rose(lck) |-> lck [*4] ##1 !lck)
    else $error("link clock half period wrong");
  ca_sync_a: assert property (
    ($changed(ca_rise) || $changed(ca_fall)) |-> fall)
    else $error("command bus moved off a link clock fall");
  dq_sync_a: assert property ($changed(dq_valid) |-> fall)
    else $error("data valid moved off a link clock fall");
  burst_len_a: assert property (
    $fell(dq_valid) |-> vcnt_reg[6:0] == 7'h00)
    else $error("burst not a whole multiple of sixteen beats");
  mask_slot_a: assert property (
    (is_cmd && cmd == CMD_WDM) |-> ##8 (rise && mslot_reg
      && ca_rise[9:8] == 2'h0 && ca_fall[9:8] == 2'h0))
    else $error("mask cycle missing or carries extra bits");
  wr_space_a: assert property (
    is_wr |-> wgap_reg >= 4'(T_CCD_S - 1))
    else $error("writes too close");
  wtr_gap_a: assert property (is_rd |-> wgap_reg >= 4'(T_WTR_S - 1))
    else $error("read too soon after write");
  act_first_a: assert property ((is_wr || is_rd) |-> open_reg[bank])
    else $error("access to a bank never activated");
  wr_data_a: assert property (is_wr |-> ##[1:300] dq_valid)
    else $error("write without data burst");
endmodule

// >>> verification/masked_write_command_path_tb_top.sv
`timescale 1ns/1ps
module masked_write_command_path_tb_top;
  import mwcp_pkg::*;
  localparam int EW = 1 + BANK_W + COL_W + 4 + DQ_W;
  typedef struct packed {
    logic [2:0]        cmd;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
    logic              ap;
    logic [MASK_W-1:0] mask;
    logic              rmw;
  } mwcp_row_t;
  // Request, then the read-modify-write flag its beats must carry
  localparam mwcp_row_t ROWS [8] = '{
    '{CMD_ACT, 4'h0, 6'h00, 1'b0, 16'h0000, 1'b0},
    '{CMD_ACT, 4'h4, 6'h00, 1'b0, 16'h0000, 1'b0},
    '{CMD_WOM, 4'h0, 6'h01, 1'b0, 16'hffff, 1'b0},
    '{CMD_WDM, 4'h4, 6'h02, 1'b0, 16'h00ff, 1'b0},
    '{CMD_WDM, 4'h4, 6'h03, 1'b0, 16'hff00, 1'b1},
    '{CMD_READ, 4'h0, 6'h04, 1'b0, 16'h0000, 1'b0},
    '{CMD_WDM, 4'h4, 6'h05, 1'b1, 16'h5555, 1'b0},
    '{CMD_WOM, 4'h0, 6'h06, 1'b1, 16'h0000, 1'b0}
  };
  logic              i_clk = 1'b0;
  logic              i_rstn = 1'b0;
  logic              req_valid = 1'b0;
  logic [2:0]        req_cmd = 3'h0;
  logic [BANK_W-1:0] req_bank = '0;
  logic [COL_W-1:0]  req_col = '0;
  logic              req_ap = 1'b0;
  logic [MASK_W-1:0] req_mask = '0;
  logic [DQ_W-1:0]   data_w = 16'h1000;
  logic [DQ_W-1:0]   dnext = 16'h1000;
  logic              wr_ready = 1'b0;
  logic              stall = 1'b1;
  logic              groups_on = 1'b1;
  logic [1:0]        rcnt = 2'h0;
  logic              lck_q = 1'b0;
  logic              mslot = 1'b0;
  logic [EW-1:0]     e;
  logic              req_ready;
  logic              data_ready;
  logic              wr_valid;
  logic              wr_rmw;
  logic              pre_valid;
  logic [BANK_W-1:0] wr_bank;
  logic [BANK_W-1:0] pre_bank;
  logic [COL_W+3:0]  wr_addr;
  logic [DQ_W-1:0]   wr_data;
  int                err_total = 0;
  int                compares = 0;
  logic [EW-1:0]     exp_q [$];
  logic [MASK_W-1:0] mask_q [$];
  logic [BANK_W-1:0] pre_q [$];
  // Free-running system clock
  always #12.5 i_clk = ~i_clk;
  mwcp_link_if mwcp_link_if_i ();
  wire [CA_W-1:0] ca_r = mwcp_link_if_i.ca_rise;
  wire [CA_W-1:0] ca_f = mwcp_link_if_i.ca_fall;
  mwcp_host mwcp_host_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_req_valid(req_valid),
    .i_req_cmd(req_cmd), .i_req_bank(req_bank), .i_req_col(req_col),
    .i_req_ap(req_ap), .i_req_mask(req_mask),
    .i_bank_groups_on(groups_on),
    .o_req_ready(req_ready), .i_data_valid(1'b1), .i_data(data_w),
    .o_data_ready(data_ready), .link(mwcp_link_if_i));
  mwcp_device mwcp_device_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .link(mwcp_link_if_i),
    .o_wr_valid(wr_valid), .o_wr_bank(wr_bank), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .o_wr_rmw(wr_rmw), .i_wr_ready(wr_ready),
    .o_pre_valid(pre_valid), .o_pre_bank(pre_bank));
  mwcp_sva mwcp_sva_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .lck(mwcp_link_if_i.lck),
    .ca_rise(ca_r), .ca_fall(ca_f), .dq(mwcp_link_if_i.dq),
    .dq_valid(mwcp_link_if_i.dq_valid),
    .write_done(mwcp_link_if_i.write_done));
  task automatic check(input logic [EW-1:0] got, input logic [EW-1:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Hold the request until taken, then book the beats that must follow
  task automatic send(input mwcp_row_t r);
    int n;
    @(posedge i_clk);
    req_valid <= 1'b1;
    req_cmd <= r.cmd;
    req_bank <= r.bank;
    req_col <= r.col;
    req_ap <= r.ap;
    req_mask <= r.mask;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    check(EW'(n < 3000), EW'(1'b1));
    if (r.cmd == CMD_WOM || r.cmd == CMD_WDM) begin
      for (int b = 0; b < BURST_LEN; b++) begin
        if (r.cmd == CMD_WOM || !r.mask[b])
          exp_q.push_back({r.rmw, r.bank, r.col, 4'(b), dnext + DQ_W'(b)});
      end
      dnext = dnext + 16'h0010;
      if (r.cmd == CMD_WDM) mask_q.push_back(r.mask);
      if (r.ap) pre_q.push_back(r.bank);
    end
  endtask
  // Wait until every booked beat, precharge and mask has shown up
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() + pre_q.size() + mask_q.size() != 0 && n < 6000) begin
      @(posedge i_clk);
      n++;
    end
    check(EW'(exp_q.size() + pre_q.size() + mask_q.size()), '0);
  endtask
  task automatic close_out();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // New data word only once the host took one; back end holds until write_done, then stalls 1 in 4
  always @(posedge i_clk) begin
    if (data_ready === 1'b1) data_w <= data_w + 16'h0001;
    rcnt <= rcnt + 2'h1;
    wr_ready <= !stall && rcnt != 2'h0;
  end
  // Score stored beats, precharges and the mask slot on the wire
  always @(posedge i_clk) begin
    lck_q <= mwcp_link_if_i.lck;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      check({wr_rmw, wr_bank, wr_addr, wr_data}, e);
    end
    if (pre_valid === 1'b1) begin
      e = pre_q.size() > 0 ? EW'(pre_q.pop_front()) : '1;
      check(EW'(pre_bank), e);
    end
    if (mwcp_link_if_i.lck === 1'b1 && lck_q === 1'b0) begin
      if (mslot) begin
        e = mask_q.size() > 0 ? EW'(mask_q.pop_front()) : '1;
        check(EW'({ca_f[7:0], ca_r[7:0]}), e);
      end
      mslot = !mslot && ca_r[9:7] === CMD_WDM;
    end
  end
  // Main sequence: table, mid-run reset, refused write, recovery
  initial begin
    int j;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    fork
      begin
        int k;
        k = 0;
        while (mwcp_link_if_i.write_done !== 1'b1 && k < 3000) begin
          @(posedge i_clk);
          k++;
        end
        check(EW'(mwcp_link_if_i.write_done), EW'(1'b1));
        stall <= 1'b0;
      end
    join_none
    foreach (ROWS[i]) send(ROWS[i]);
    drain();
    i_rstn <= 1'b0;
    @(posedge i_clk);
    #1;
    check(EW'({req_ready, wr_valid, pre_valid, mwcp_link_if_i.dq_valid}), '0);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    groups_on <= 1'b0;
    @(posedge i_clk);
    req_valid <= 1'b1;
    req_cmd <= CMD_WOM;
    req_bank <= 4'h9;
    j = 0;
    repeat (60) begin
      @(posedge i_clk);
      if (req_ready !== 1'b0) j++;
    end
    req_valid <= 1'b0;
    check(EW'(j), '0);
    send(mwcp_row_t'{CMD_ACT, 4'h9, 6'h00, 1'b0, 16'h0000, 1'b0});
    send(mwcp_row_t'{CMD_WDM, 4'h9, 6'h0f, 1'b0, 16'h8001, 1'b0});
    drain();
    close_out();
  end
  // A run of under two thousand cycles; this cuts off a hang
  initial begin
    #1000000;
    err_total++;
    close_out();
  end
endmodule
